//--- design/sc_etu_guard.v
// Overview of operation
// - Clock rate code selects Fi table value
// - Baud adjust code selects Di table value
// - ETU divider equals rounded twice Fi over Di
// - Inexact divisors rounded to nearest whole count
// - Check register bytes reset to FF
// - T1 with enable appends check code after message
// - LRC uses only check low byte
// - CRC polynomial x16 plus x12 plus x5 plus 1
// - CRC computed on direct convention byte values
// - Received check bytes also go to FIFO
// - T1 bytes update check register, except transmitted appended check bytes
// - Check register readable with running value
// - Appended code obeys normal character spacing
// - Transmit after a received start bit waits for block guard time
// - Extra guard nine bits spaces transmit starts
// - Extra guard floor twelve T0, eleven T1
// - ETU from rate register nibbles, default 11
`timescale 1ns/1ps
`include "sc_guard_map.vh"

module sc_etu_guard #(
   parameter ADDR_W = 20
)(
   input  wire              CLK_IN,
   input  wire              RST_IN,
   input  wire [ADDR_W-1:0] PADDR_IN,
   input  wire              PSEL_IN,
   input  wire              PENABLE_IN,
   input  wire              PWRITE_IN,
   input  wire [31:0]       PWDATA_IN,
   output wire [31:0]       PRDATA_OUT,
   output wire              PREADY_OUT,
   output wire              PSLVERR_OUT,
   input  wire              TX_START_IN,
   input  wire [7:0]        TX_DATA_IN,
   input  wire              TX_LAST_IN,
   input  wire              RX_START_IN,
   input  wire              RX_BYTE_VALID_IN,
   input  wire [7:0]        RX_DATA_IN,
   output wire              TX_GO_OUT,
   output wire              CHK_VALID_OUT,
   output wire [7:0]        CHK_BYTE_OUT,
   output wire              RX_FIFO_VALID_OUT,
   output wire [7:0]        RX_FIFO_DATA_OUT,
   output wire [12:0]       ETU_DIV_OUT,
   output wire              ETU_TICK_OUT
);

   // Register storage
   reg  [7:0]  control;
   reg  [7:0]  rate_factor_register;
   reg  [7:0]  check_code_high_byte;
   reg  [7:0]  check_code_low_byte;
   reg  [7:0]  block_guard_time;
   reg  [7:0]  extra_guard_time_low;
   reg  [31:0] rdata;
   reg         slverr;

   // Timing and framing state
   reg  [12:0] etu_div;
   reg  [12:0] etu_cnt;
   reg         etu_tick;
   reg  [8:0]  egt_cnt;
   reg  [4:0]  bgt_cnt;
   reg         bgt_pending;
   reg         egt_pending;
   reg  [1:0]  append_left;
   reg  [7:0]  chk_byte;
   reg         rx_fifo_valid;
   reg  [7:0]  rx_fifo_data;

   // Combinational values
   reg  [11:0] fi_value;
   reg  [5:0]  di_value;
   reg  [12:0] next_etu_div;
   reg  [15:0] next_check;
   reg  [7:0]  upd_byte;
   reg         upd_en;
   reg  [8:0]  egt_eff;
   reg         mapped;
   reg  [31:0] rd_mux;

   wire [17:0] idx       = PADDR_IN[19:2];
   wire        setup     = PSEL_IN & ~PENABLE_IN;
   wire        wr_access = PSEL_IN & PENABLE_IN & PWRITE_IN & ~slverr;
   wire        t1_mode   = control[`CTL_T1_MODE];
   wire        gen_en    = control[`CTL_CHECK_GEN_EN];
   wire        lrc_mode  = control[`CTL_LRC_MODE];
   wire [3:0]  f_code    = rate_factor_register[`RATE_F_MSB:`RATE_F_LSB];
   wire [3:0]  d_code    = rate_factor_register[`RATE_D_MSB:`RATE_D_LSB];
   wire [4:0]  bgt_field = block_guard_time[`BGT_FIELD_MSB:0];
   wire [8:0]  egt_field = {block_guard_time[`BGT_EGT_MSB_BIT], extra_guard_time_low};
   wire        appending = (append_left != 2'b00);
   wire        tx_char   = TX_START_IN & ~appending;
   wire        tx_go     = ~bgt_pending & ~egt_pending;

   // CRC step over one byte, most significant bit first
   function [15:0] crc_byte;
      input [15:0] crc_in;
      input [7:0]  data;
      integer      i;
      reg   [15:0] c;
      begin
         c = crc_in;
         for (i = 7; i >= 0; i = i - 1)
         begin
            if (c[15] ^ data[i])
               c = {c[14:0], 1'b0} ^ `CRC_POLY;
            else
               c = {c[14:0], 1'b0};
         end
         crc_byte = c;
      end
   endfunction

   always @*
   begin
      case (f_code)
         4'h0, 4'h1: fi_value = 12'd372;
         4'h2:       fi_value = 12'd558;
         4'h3:       fi_value = 12'd744;
         4'h4:       fi_value = 12'd1116;
         4'h5:       fi_value = 12'd1488;
         4'h6, 4'h7: fi_value = 12'd1860;
         4'h8, 4'h9: fi_value = 12'd512;
         4'hA:       fi_value = 12'd768;
         4'hB:       fi_value = 12'd1024;
         4'hC:       fi_value = 12'd1536;
         default:    fi_value = 12'd2048;
      endcase
   end

   always @*
   begin
      case (d_code)
         4'h0, 4'h1: di_value = 6'd1;
         4'h2:       di_value = 6'd2;
         4'h3:       di_value = 6'd4;
         4'h4:       di_value = 6'd8;
         4'h5:       di_value = 6'd16;
         4'h6, 4'h7: di_value = 6'd32;
         4'h8:       di_value = 6'd12;
         4'h9:       di_value = 6'd20;
         default:    di_value = 6'd16;
      endcase
   end

   // Twice Fi over Di; adding half of Di rounds to nearest
   // keeps inexact ratios within a fraction of a count
   always @*
   begin
      // Widest sum is 4096 plus 16, so thirteen bits never overflow
      next_etu_div = (({1'b0, fi_value} << 1) + {7'h00, di_value[5:1]})
                     / {7'h00, di_value};
   end

   // Extra guard floor depends on protocol
   always @*
   begin
      egt_eff = egt_field;
      if (t1_mode && egt_field < `EGT_MIN_T1)
         egt_eff = `EGT_MIN_T1;
      else if (!t1_mode && egt_field < `EGT_MIN_T0)
         egt_eff = `EGT_MIN_T0;
   end

   // Byte feeding the check register: transmitted data or received data
   always @*
   begin
      upd_en   = 1'b0;
      upd_byte = RX_DATA_IN;
      // Update in T1 regardless of enable
      if (t1_mode && tx_char)
      begin
         upd_en   = 1'b1;
         upd_byte = TX_DATA_IN;
      end
      else if (t1_mode && RX_BYTE_VALID_IN)
      begin
         upd_en = 1'b1;
      end
   end

   // Bytes arrive in direct convention so CRC is convention free
   always @*
   begin
      if (lrc_mode)
         // Only the low byte carries the LRC
         next_check = {check_code_high_byte, check_code_low_byte ^ upd_byte};
      else
         next_check = crc_byte({check_code_high_byte, check_code_low_byte}, upd_byte);
   end

   // ETU divider: count registered so a rate change settles in one cycle
   // Rate register nibbles drive the divider
   always @(posedge CLK_IN or posedge RST_IN)
   begin
      if (RST_IN)
      begin
         etu_div  <= `RST_ETU_DIV;
         etu_cnt  <= 13'h0000;
         etu_tick <= 1'b0;
      end
      else
      begin
         etu_div  <= next_etu_div;
         // Phase restarts at each start bit so guard counts align to edges
         if (TX_START_IN || RX_START_IN || etu_cnt >= etu_div - 13'h0001)
            etu_cnt <= 13'h0000;
         else
            etu_cnt <= etu_cnt + 13'h0001;
         etu_tick <= ~(TX_START_IN | RX_START_IN) & (etu_cnt >= etu_div - 13'h0001);
      end
   end

   // Guard timers
   always @(posedge CLK_IN or posedge RST_IN)
   begin
      if (RST_IN)
      begin
         bgt_cnt     <= 5'h00;
         bgt_pending <= 1'b0;
         egt_cnt     <= 9'h000;
         egt_pending <= 1'b0;
      end
      else
      begin
         // Block guard starts at received start bit
         if (RX_START_IN)
         begin
            bgt_cnt     <= 5'h00;
            bgt_pending <= (bgt_field != 5'h00);
         end
         else if (bgt_pending && etu_tick)
         begin
            bgt_cnt <= bgt_cnt + 5'h01;
            if (bgt_cnt + 5'h01 >= bgt_field)
               bgt_pending <= 1'b0;
         end
         // Check bytes start through the same gate
         if (TX_START_IN)
         begin
            egt_cnt     <= 9'h000;
            egt_pending <= 1'b1;
         end
         else if (egt_pending && etu_tick)
         begin
            egt_cnt <= egt_cnt + 9'h001;
            if (egt_cnt + 9'h001 >= egt_eff)
               egt_pending <= 1'b0;
         end
      end
   end

   // Check register, append sequencing and receive forwarding
   always @(posedge CLK_IN or posedge RST_IN)
   begin
      if (RST_IN)
      begin
         check_code_high_byte <= `RST_CHECK_HIGH;
         check_code_low_byte  <= `RST_CHECK_LOW;
         append_left          <= 2'b00;
         chk_byte             <= 8'h00;
         rx_fifo_valid        <= 1'b0;
         rx_fifo_data         <= 8'h00;
      end
      else
      begin
         // Firmware reload wins over a same-cycle update
         if (wr_access && idx == `IDX_CHECK_HIGH)
            check_code_high_byte <= PWDATA_IN[7:0];
         else if (upd_en)
            check_code_high_byte <= next_check[15:8];
         if (wr_access && idx == `IDX_CHECK_LOW)
            check_code_low_byte <= PWDATA_IN[7:0];
         else if (upd_en)
            check_code_low_byte <= next_check[7:0];
         // Last byte with generation on starts the append
         if (tx_char && TX_LAST_IN && t1_mode && gen_en)
         begin
            append_left <= lrc_mode ? 2'b01 : 2'b10;
            chk_byte    <= lrc_mode ? next_check[7:0] : next_check[15:8];
         end
         else if (TX_START_IN && appending)
         begin
            append_left <= append_left - 2'b01;
            chk_byte    <= check_code_low_byte;
         end
         // Every received byte, check bytes included, goes on
         rx_fifo_valid <= RX_BYTE_VALID_IN;
         if (RX_BYTE_VALID_IN)
            rx_fifo_data <= RX_DATA_IN;
      end
   end

   // APB read selection and decode
   // Running check value readable at any time
   always @*
   begin
      mapped = 1'b1;
      rd_mux = 32'h00000000;
      case (idx)
         `IDX_CONTROL:     rd_mux[7:0] = control;
         `IDX_STATUS:      rd_mux[2:0] = {bgt_pending, appending, tx_go};
         `IDX_RATE:        rd_mux[7:0] = rate_factor_register;
         `IDX_CHECK_HIGH:  rd_mux[7:0] = check_code_high_byte;
         `IDX_CHECK_LOW:   rd_mux[7:0] = check_code_low_byte;
         `IDX_BLOCK_GUARD: rd_mux[7:0] = block_guard_time & 8'h9F;
         `IDX_EXTRA_GUARD: rd_mux[7:0] = extra_guard_time_low;
         default:          mapped = 1'b0;
      endcase
   end

   // APB slave: read data and error latched in the setup cycle
   always @(posedge CLK_IN or posedge RST_IN)
   begin
      if (RST_IN)
      begin
         rdata                <= 32'h00000000;
         slverr               <= 1'b0;
         control              <= `RST_CONTROL;
         rate_factor_register <= `RST_RATE;
         block_guard_time     <= `RST_BLOCK_GUARD;
         extra_guard_time_low <= `RST_EXTRA_GUARD;
      end
      else
      begin
         if (setup)
         begin
            rdata  <= rd_mux;
            slverr <= ~mapped | (PWRITE_IN && idx == `IDX_STATUS);
         end
         if (wr_access)
         begin
            case (idx)
               `IDX_CONTROL:     control <= PWDATA_IN[7:0] & 8'h07;
               `IDX_RATE:        rate_factor_register <= PWDATA_IN[7:0];
               `IDX_BLOCK_GUARD: block_guard_time <= PWDATA_IN[7:0] & 8'h9F;
               `IDX_EXTRA_GUARD: extra_guard_time_low <= PWDATA_IN[7:0];
               default:          control <= control;
            endcase
         end
      end
   end

   assign PRDATA_OUT        = rdata;
   assign PREADY_OUT        = 1'b1;
   assign PSLVERR_OUT       = PSEL_IN & PENABLE_IN & slverr;
   assign TX_GO_OUT         = tx_go;
   assign CHK_VALID_OUT     = appending;
   assign CHK_BYTE_OUT      = chk_byte;
   assign RX_FIFO_VALID_OUT = rx_fifo_valid;
   assign RX_FIFO_DATA_OUT  = rx_fifo_data;
   assign ETU_DIV_OUT       = etu_div;
   assign ETU_TICK_OUT      = etu_tick;

endmodule

//--- design/sc_guard_map.vh
`ifndef SC_GUARD_MAP_VH
`define SC_GUARD_MAP_VH

// Register indices; byte address is four times the index
`define IDX_CONTROL         18'h0FE10
`define IDX_STATUS          18'h0FE11
`define IDX_RATE            18'h0FE13
`define IDX_CHECK_HIGH      18'h0FE14
`define IDX_CHECK_LOW       18'h0FE15
`define IDX_BLOCK_GUARD     18'h0FE16
`define IDX_EXTRA_GUARD     18'h0FE17

// Reset values
`define RST_CONTROL         8'h00
`define RST_RATE            8'h11
`define RST_CHECK_HIGH      8'hFF
`define RST_CHECK_LOW       8'hFF
`define RST_BLOCK_GUARD     8'h10
`define RST_EXTRA_GUARD     8'h0C
`define RST_ETU_DIV         13'h02E8

// Control fields
`define CTL_T1_MODE         0
`define CTL_CHECK_GEN_EN    1
`define CTL_LRC_MODE        2

// Status fields
`define STS_TX_GO           0
`define STS_APPEND_BUSY     1
`define STS_BGT_PENDING     2

// Block guard register fields
`define BGT_FIELD_MSB       4
`define BGT_EGT_MSB_BIT     7

// Rate register fields
`define RATE_F_MSB          7
`define RATE_F_LSB          4
`define RATE_D_MSB          3
`define RATE_D_LSB          0

// Extra guard floors in ETUs
`define EGT_MIN_T0          9'h00C
`define EGT_MIN_T1          9'h00B

// Check code polynomial, x^16 + x^12 + x^5 + 1
`define CRC_POLY            16'h1021

`endif

//--- testbench/sc_card_model.sv
`timescale 1ns/1ps
module sc_card_model (
   input  wire       clk_in,
   input  wire       tick_in,
   input  wire       tx_go_in,
   output reg        tx_start_out = 1'b0,
   output reg  [7:0] tx_data_out = 8'h00,
   output reg        tx_last_out = 1'b0,
   output reg        rx_start_out = 1'b0,
   output reg        rx_valid_out = 1'b0,
   output reg  [7:0] rx_data_out = 8'h00
);
   // Card character: start edge, ten ETUs, then byte; data inverted when idle
   task card_send(input [7:0] d);
      begin
         @(posedge clk_in) rx_start_out <= 1'b1;
         @(posedge clk_in) rx_start_out <= 1'b0;
         repeat (10) @(posedge tick_in);
         @(posedge clk_in) rx_valid_out <= 1'b1;
         rx_data_out <= d;
         @(posedge clk_in) rx_valid_out <= 1'b0;
         rx_data_out <= ~d;
      end
   endtask
   // Line transmitter: starts on go or after 5000 cycles without it, returns ticks until go again
   task xmit(input [7:0] d, input last, output integer n);
      integer i;
      begin
         for (i = 0; i < 5000 && tx_go_in !== 1'b1; i = i + 1)
            @(posedge clk_in);
         @(posedge clk_in) tx_start_out <= 1'b1;
         tx_data_out <= d;
         tx_last_out <= last;
         @(posedge clk_in) tx_start_out <= 1'b0;
         tx_data_out <= ~d;
         tx_last_out <= 1'b0;
         n = 0;
         do
         begin
            @(posedge clk_in);
            n = n + tick_in;
         end
         while (tx_go_in !== 1'b1);
      end
   endtask
endmodule

//--- testbench/sc_etu_guard_chk.sv
`timescale 1ns/1ps
module sc_etu_guard_chk #(
   parameter ADDR_W = 20
)(
   input wire        CLK_IN,
   input wire        RST_IN,
   input wire        TX_START_IN,
   input wire        TX_LAST_IN,
   input wire        RX_BYTE_VALID_IN,
   input wire [7:0]  RX_DATA_IN,
   input wire        TX_GO_OUT,
   input wire        CHK_VALID_OUT,
   input wire        RX_FIFO_VALID_OUT,
   input wire [7:0]  RX_FIFO_DATA_OUT,
   input wire [12:0] ETU_DIV_OUT,
   input wire        ETU_TICK_OUT
);
   reg [7:0] tk;
   default clocking @(posedge CLK_IN);
   endclocking
   default disable iff (RST_IN);
   // Ticks since last start; saturates so idle never looks short
   always @(posedge CLK_IN or posedge RST_IN)
   begin
      if (RST_IN)
         tk <= 8'hFF;
      else if (TX_START_IN)
         tk <= 8'h00;
      else if (ETU_TICK_OUT && tk != 8'hFF)
         tk <= tk + 8'h01;
   end
   property p_fifo_copy;
      RX_BYTE_VALID_IN |=> RX_FIFO_VALID_OUT && RX_FIFO_DATA_OUT == $past(RX_DATA_IN);
   endproperty
   a_fifo_copy: assert property (p_fifo_copy) else $error("fifo copy wrong");
   property p_fifo_only;
      !RX_BYTE_VALID_IN |=> !RX_FIFO_VALID_OUT;
   endproperty
   a_fifo_only: assert property (p_fifo_only) else $error("stray fifo push");
   property p_tx_hold;
      TX_START_IN |=> !TX_GO_OUT;
   endproperty
   a_tx_hold: assert property (p_tx_hold) else $error("go not dropped");
   property p_egt_floor;
      $rose(TX_GO_OUT) |-> (tk + ETU_TICK_OUT) >= 9'h00B;
   endproperty
   a_egt_floor: assert property (p_egt_floor) else $error("spacing too short");
   property p_append;
      $rose(CHK_VALID_OUT) |-> $past(TX_START_IN && TX_LAST_IN);
   endproperty
   a_append: assert property (p_append) else $error("append without last");
   property p_div_reset;
      $fell(RST_IN) |-> ETU_DIV_OUT == 13'h02E8;
   endproperty
   a_div_reset: assert property (p_div_reset) else $error("divider reset wrong");
   property p_div_range;
      ETU_DIV_OUT >= 13'h0017 && ETU_DIV_OUT <= 13'h1000;
   endproperty
   a_div_range: assert property (p_div_range) else $error("divider out of range");
   property p_tick_gap;
      ETU_TICK_OUT |=> !ETU_TICK_OUT [*8];
   endproperty
   a_tick_gap: assert property (p_tick_gap) else $error("ticks too close");
endmodule
bind sc_etu_guard sc_etu_guard_chk #(.ADDR_W(ADDR_W)) u_sc_etu_guard_chk (
   .CLK_IN(CLK_IN), .RST_IN(RST_IN), .TX_START_IN(TX_START_IN), .TX_LAST_IN(TX_LAST_IN),
   .RX_BYTE_VALID_IN(RX_BYTE_VALID_IN), .RX_DATA_IN(RX_DATA_IN), .TX_GO_OUT(TX_GO_OUT),
   .CHK_VALID_OUT(CHK_VALID_OUT), .RX_FIFO_VALID_OUT(RX_FIFO_VALID_OUT),
   .RX_FIFO_DATA_OUT(RX_FIFO_DATA_OUT), .ETU_DIV_OUT(ETU_DIV_OUT), .ETU_TICK_OUT(ETU_TICK_OUT));

//--- testbench/smartcard_etu_crc_guard_tb.sv
`timescale 1ns/1ps
`include "sc_guard_map.vh"
module smartcard_etu_crc_guard_tb;
   reg         clk = 1'b0;
   reg         rst = 1'b1;
   reg  [19:0] paddr = 20'h00000;
   reg         psel = 1'b0;
   reg         penable = 1'b0;
   reg         pwrite = 1'b0;
   reg  [31:0] pwdata = 32'h0;
   wire [31:0] prdata;
   wire        pready, pslverr, tx_start, tx_last, rx_start, rx_valid;
   wire        tx_go, chk_valid, fifo_valid, tick;
   wire [7:0]  tx_data, rx_data, chk_byte, fifo_data;
   wire [12:0] etu_div;
   reg  [31:0] r;
   reg         e;
   reg  [15:0] c;
   reg  [7:0]  bt, rt;
   integer     error_cnt = 0, checked = 0, n, i;
   sc_etu_guard u_sc_etu_guard (.CLK_IN(clk), .RST_IN(rst), .PADDR_IN(paddr), .PSEL_IN(psel),
      .PENABLE_IN(penable), .PWRITE_IN(pwrite), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata),
      .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .TX_START_IN(tx_start), .TX_DATA_IN(tx_data),
      .TX_LAST_IN(tx_last), .RX_START_IN(rx_start), .RX_BYTE_VALID_IN(rx_valid),
      .RX_DATA_IN(rx_data), .TX_GO_OUT(tx_go), .CHK_VALID_OUT(chk_valid), .CHK_BYTE_OUT(chk_byte),
      .RX_FIFO_VALID_OUT(fifo_valid), .RX_FIFO_DATA_OUT(fifo_data), .ETU_DIV_OUT(etu_div),
      .ETU_TICK_OUT(tick));
   sc_card_model u_sc_card_model (.clk_in(clk), .tick_in(tick), .tx_go_in(tx_go),
      .tx_start_out(tx_start), .tx_data_out(tx_data), .tx_last_out(tx_last),
      .rx_start_out(rx_start), .rx_valid_out(rx_valid), .rx_data_out(rx_data));
   always #50 clk = ~clk;
   // Rounded twice Fi over Di, half rounds up
   function [12:0] div_of(input [7:0] rc);
      integer f, d;
      begin
         case (rc[7:4])
            0, 1: f = 372;  2: f = 558;   3: f = 744;    4: f = 1116;   5: f = 1488;
            6, 7: f = 1860; 8, 9: f = 512; 10: f = 768;  11: f = 1024;  12: f = 1536;
            default: f = 2048;
         endcase
         case (rc[3:0])
            0, 1: d = 1; 2: d = 2; 3: d = 4; 4: d = 8; 5: d = 16; 6, 7: d = 32;
            8: d = 12;   9: d = 20; default: d = 16;
         endcase
         div_of = (2 * f + d / 2) / d;
      end
   endfunction
   // One byte through the check code, most significant bit first
   function [15:0] crc_step(input [15:0] s, input [7:0] b);
      integer k;
      begin
         for (k = 7; k >= 0; k = k - 1)
            s = {s[14:0], 1'b0} ^ ((s[15] ^ b[k]) ? `CRC_POLY : 16'h0000);
         crc_step = s;
      end
   endfunction
   task chk(input string nm, input [31:0] x, input [31:0] g);
      begin
         checked = checked + 1;
         if (x !== g)
         begin
            $display("ERROR %s expected %h seen %h", nm, x, g);
            error_cnt = error_cnt + 1;
         end
      end
   endtask
   // Setup then access, held until ready is seen
   task apb(input [17:0] idx, input w, input [7:0] d);
      begin
         @(posedge clk) psel <= 1'b1;
         paddr <= {idx, 2'b00};
         pwrite <= w;
         pwdata <= {24'h000000, d};
         @(posedge clk) penable <= 1'b1;
         do
            @(posedge clk);
         while (pready !== 1'b1);
         r = prdata;
         e = pslverr;
         psel <= 1'b0;
         penable <= 1'b0;
      end
   endtask
   task rd(input [17:0] idx, input [7:0] x);
      begin
         apb(idx, 1'b0, 8'h00);
         chk("rdata", {24'h000000, x}, r);
      end
   endtask
   task results;
      begin
         $display("checks %0d errors %0d", checked, error_cnt);
         if (error_cnt == 0 && checked > 0)
            $display("All checks passed");
         else
            $display("Checks failed");
         $finish;
      end
   endtask
   // Watchdog well beyond the longest guard run
   initial
   begin
      repeat (60000) @(posedge clk);
      error_cnt = error_cnt + 1;
      results;
   end
   initial
   begin
      void'($urandom(17));
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      rd(`IDX_CHECK_HIGH, 8'hFF);
      rd(`IDX_CHECK_LOW, 8'hFF);
      rd(`IDX_BLOCK_GUARD, 8'h10);
      rd(`IDX_EXTRA_GUARD, 8'h0C);
      rd(`IDX_RATE, 8'h11);
      rd(18'h0FE12, 8'h00);
      chk("unmapped", 32'h1, e);
      apb(`IDX_STATUS, 1'b1, 8'hFF);
      chk("ro write", 32'h1, e);
      apb(`IDX_BLOCK_GUARD, 1'b1, 8'hFF);
      rd(`IDX_BLOCK_GUARD, 8'h9F);
      // Rate table corners, then random codes
      for (i = 0; i < 20; i = i + 1)
      begin
         rt = (i == 0) ? 8'h98 : (i == 1) ? 8'hD1 : (i == 2) ? 8'h42 : $urandom;
         apb(`IDX_RATE, 1'b1, rt);
         repeat (3) @(posedge clk);
         chk("divider", {19'h0, div_of(rt)}, {19'h0, etu_div});
      end
      apb(`IDX_RATE, 1'b1, 8'h96);
      apb(`IDX_BLOCK_GUARD, 1'b1, 8'h0C);
      // Extra guard: floors, plain count, ninth bit
      apb(`IDX_CONTROL, 1'b1, 8'h00);
      apb(`IDX_EXTRA_GUARD, 1'b1, 8'h01);
      u_sc_card_model.xmit(8'h5A, 1'b0, n);
      chk("t0 floor", 32'hC, n);
      apb(`IDX_EXTRA_GUARD, 1'b1, 8'h14);
      u_sc_card_model.xmit(8'hA5, 1'b0, n);
      chk("egt", 32'h14, n);
      apb(`IDX_BLOCK_GUARD, 1'b1, 8'h8C);
      apb(`IDX_EXTRA_GUARD, 1'b1, 8'h04);
      u_sc_card_model.xmit(8'h3C, 1'b0, n);
      chk("egt msb", 32'h104, n);
      apb(`IDX_BLOCK_GUARD, 1'b1, 8'h0C);
      apb(`IDX_EXTRA_GUARD, 1'b1, 8'h01);
      apb(`IDX_CONTROL, 1'b1, 8'h01);
      u_sc_card_model.xmit(8'hC3, 1'b0, n);
      chk("t1 floor", 32'hB, n);
      apb(`IDX_EXTRA_GUARD, 1'b1, 8'h0C);
      // Transmit message with appended check code; seed reloaded first
      apb(`IDX_CONTROL, 1'b1, 8'h03);
      apb(`IDX_CHECK_HIGH, 1'b1, 8'hFF);
      apb(`IDX_CHECK_LOW, 1'b1, 8'hFF);
      c = 16'hFFFF;
      for (i = 0; i < 3; i = i + 1)
      begin
         bt = $urandom;
         c = crc_step(c, bt);
         u_sc_card_model.xmit(bt, i == 2, n);
      end
      rd(`IDX_CHECK_HIGH, c[15:8]);
      rd(`IDX_CHECK_LOW, c[7:0]);
      chk("chk valid", 32'h1, chk_valid);
      chk("chk high", c[15:8], chk_byte);
      u_sc_card_model.xmit(8'hFF, 1'b0, n);
      chk("chk spacing", 32'hC, n);
      chk("chk low", c[7:0], chk_byte);
      u_sc_card_model.xmit(8'hFF, 1'b0, n);
      chk("chk done", 32'h0, chk_valid);
      // Longitudinal code: one appended byte
      apb(`IDX_CONTROL, 1'b1, 8'h07);
      apb(`IDX_CHECK_LOW, 1'b1, 8'h00);
      c = 16'h0000;
      for (i = 0; i < 2; i = i + 1)
      begin
         bt = $urandom;
         c[7:0] = c[7:0] ^ bt;
         u_sc_card_model.xmit(bt, i == 1, n);
      end
      chk("lrc byte", c[7:0], chk_byte);
      u_sc_card_model.xmit(8'h00, 1'b0, n);
      chk("lrc done", 32'h0, chk_valid);
      // Receive with generation off, block guard then holds transmit
      apb(`IDX_CONTROL, 1'b1, 8'h01);
      apb(`IDX_CHECK_HIGH, 1'b1, 8'hFF);
      apb(`IDX_CHECK_LOW, 1'b1, 8'hFF);
      c = 16'hFFFF;
      for (i = 0; i < 2; i = i + 1)
      begin
         bt = $urandom;
         c = crc_step(c, bt);
         u_sc_card_model.card_send(bt);
      end
      chk("bgt hold", 32'h0, tx_go);
      rd(`IDX_STATUS, 8'h04);
      rd(`IDX_CHECK_HIGH, c[15:8]);
      rd(`IDX_CHECK_LOW, c[7:0]);
      // Received message plus its longitudinal code leaves zero
      apb(`IDX_CONTROL, 1'b1, 8'h05);
      apb(`IDX_CHECK_LOW, 1'b1, 8'h00);
      bt = $urandom;
      u_sc_card_model.card_send(bt);
      u_sc_card_model.card_send(8'h6D);
      u_sc_card_model.card_send(bt ^ 8'h6D);
      rd(`IDX_CHECK_LOW, 8'h00);
      results;
   end
endmodule
